//--- core/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // ****************************************************************
  // register map (byte addresses, 32-bit words)
  // ****************************************************************
  localparam logic [31:0] CTRL_OFF = 32'hffff0500;
  localparam logic [31:0] CHAN_OFF = 32'hffff0504;
  localparam logic [31:0] STAT_OFF = 32'hffff050c;
  localparam logic [31:0] DATA_OFF = 32'hffff0510;
  localparam logic [31:0] DAC_OFF  = 32'hffff061c;

  // ****************************************************************
  // converter_control fields
  // ****************************************************************
  localparam int CONV_LSB = 0;   // 3 bits, conversion type
  localparam int MODE_LSB = 3;   // 2 bits, input mode
  localparam int EN_BIT   = 5;   // converter enable
  localparam int ACQ_LSB  = 8;   // 2 bits, acquisition clocks = 2 << code
  localparam int DIV_LSB  = 10;  // 3 bits, divider = 1 << code

  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_DIFF   = 2'h1;
  localparam logic [1:0] MODE_PSEUDO = 2'h2;
  localparam logic [2:0] CONV_ONCE   = 3'h3;
  localparam logic [2:0] CONV_CONT   = 3'h4;

  // ****************************************************************
  // reset values and data word layout
  // ****************************************************************
  localparam logic [15:0] CTRL_RESET = 16'h0600;
  localparam logic [4:0]  CHAN_RESET = 5'h00;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [31:0] DAC_RESET  = 32'h0000_0000;
  localparam int RES_LSB  = 16;
  localparam int RES_MSB  = 27;
  localparam int SIGN_LSB = 28;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;

  // ****************************************************************
  // timing, in converter clocks
  // ****************************************************************
  localparam logic [7:0] EXTRA_CLKS    = 8'h13;  // 19: bit trials and write
  localparam logic [7:0] TEMP_ACQ_CLKS = 8'h10;  // 16
  localparam logic [2:0] TEMP_DIV_CODE = 3'h5;   // divide by 32
  localparam logic [4:0] TEMP_CHAN     = 5'h10;
  localparam logic [4:0] BUF_DAC_CHAN  = 5'h03;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACQ  = 2'b01,
    ST_CONV = 2'b11
  } conv_st_t;

  function automatic logic [7:0] acq_clocks(input logic [1:0] code);
    acq_clocks = 8'h02 << code;
  endfunction

  function automatic logic [7:0] div_ratio(input logic [2:0] code);
    div_ratio = 8'h01 << code;
  endfunction

endpackage

//--- core/adc_result_ctrl.sv
// Overview of operation
// - each 12-bit result sits in bits 16 to 27 of the 32-bit data word.
// - in fully differential mode the four bits above the result hold copies of its sign; in the other modes they are zero.
// - in fully differential mode the result is two's complement.
// - in pseudo differential and single-ended mode the result is straight binary.
// - the dac output word uses the same bit placement as the result.
// - software picks the clock divider and acquisition clocks in converter_control.
// - after reset acquisition is eight converter clocks and the divider is 2.
// - every conversion adds 19 converter clocks for bit trials and result write.
// - the temperature channel forces 16 acquisition clocks and a divider of 32.
// - after the temperature channel the programmed timing applies again.
// - converter_control enables the converter, picks input mode and conversion type.
// - on the reduced variant the fourth dac buffer feeds the buffered input channel.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module adc_result_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter logic REDUCED_VARIANT = 1'b0
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [11:0] sar_result,
  output var  logic        converter_on,
  output var  logic        conv_tick,
  output var  logic        acquire,
  output var  logic        bit_trial,
  output var  logic        conv_done,
  output var  logic [4:0]  chan_sel,
  output var  logic [1:0]  input_mode,
  output var  logic [11:0] dac_code,
  output var  logic        buffered_dac_input_channel
);
  import adc_ctrl_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [15:0] converter_control;
    logic [4:0]  chan;
    logic [31:0] dac_output_word;
    logic [31:0] data;
    logic        done;
    conv_st_t    st;
    logic [7:0]  div_cnt;
    logic [7:0]  clk_cnt;
    logic        temp;
    logic        finish;
    logic [31:0] rdata;
    logic        err;
  } state_t;

  localparam state_t RESET_STATE = '{
    converter_control: CTRL_RESET,
    chan:              CHAN_RESET,
    dac_output_word:   DAC_RESET,
    data:              DATA_RESET,
    done:              1'b0,
    st:                ST_IDLE,
    div_cnt:           8'h00,
    clk_cnt:           8'h00,
    temp:              1'b0,
    finish:            1'b0,
    rdata:             32'h0000_0000,
    err:               1'b0
  };

  state_t      cur_r;
  state_t      cur_nxt;
  logic        setup;
  logic        access;
  logic        wr_ctrl;
  logic        rd_data;
  logic        enabled;
  logic        diff_mode;
  logic [2:0]  conv_type;
  logic [2:0]  eff_div;
  logic [7:0]  acq_n;
  logic        tick;
  logic        start;
  logic        last_trial;
  logic [31:0] fmt_word;

  // the core delivers offset binary; differential mode flips the msb
  function automatic logic [31:0] format_word(input logic [11:0] raw,
                                              input logic        diff);
    logic [11:0] code;
    logic        sign;
    code = diff ? {~raw[11], raw[10:0]} : raw;
    sign = diff & code[11];
    format_word = {{4{sign}}, code, 16'h0000};
  endfunction

  // ****************************************************************
  // decode of control and timing
  // ****************************************************************
  assign enabled   = cur_r.converter_control[EN_BIT];
  assign diff_mode = cur_r.converter_control[MODE_LSB +: 2] == MODE_DIFF;
  assign conv_type = cur_r.converter_control[CONV_LSB +: 3];
  // the temperature override lives only for the conversion that latched it
  assign eff_div   = cur_r.temp ? TEMP_DIV_CODE
                                : cur_r.converter_control[DIV_LSB +: 3];
  assign acq_n     = cur_r.temp ? TEMP_ACQ_CLKS
                                : acq_clocks(cur_r.converter_control[ACQ_LSB +: 2]);
  assign tick      = (cur_r.st != ST_IDLE) &&
                     (cur_r.div_cnt == div_ratio(eff_div) - 8'h01);
  // a conversion whose enable has just dropped must not land its result
  assign last_trial = (cur_r.st == ST_CONV) && tick && enabled &&
                      (cur_r.clk_cnt == EXTRA_CLKS - 8'h01);
  assign fmt_word  = format_word(sar_result, diff_mode);

  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign wr_ctrl = access & pwrite & ~cur_r.err & (paddr == CTRL_OFF);
  assign rd_data = access & ~pwrite & ~cur_r.err & (paddr == DATA_OFF);

  // a one-shot starts on the write that asks for it; continuous restarts itself
  assign start = (cur_r.st == ST_IDLE) &&
                 ((wr_ctrl && pwdata[EN_BIT] && pwdata[CONV_LSB +: 3] == CONV_ONCE) ||
                  (!wr_ctrl && enabled && conv_type == CONV_CONT));

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.finish = 1'b0;

    // bus: decode in the setup phase so data is ready with zero wait states
    if (setup) begin
      cur_nxt.err   = 1'b0;
      cur_nxt.rdata = 32'h0000_0000;
      case (paddr)
        CTRL_OFF: cur_nxt.rdata = {16'h0000, cur_r.converter_control};
        CHAN_OFF: cur_nxt.rdata = {27'h0000000, cur_r.chan};
        STAT_OFF: begin
          cur_nxt.rdata[STAT_DONE_BIT] = cur_r.done;
          cur_nxt.rdata[STAT_BUSY_BIT] = cur_r.st != ST_IDLE;
          cur_nxt.err = pwrite;
        end
        DATA_OFF: begin
          cur_nxt.rdata = cur_r.data;
          cur_nxt.err = pwrite;
        end
        DAC_OFF:  cur_nxt.rdata = cur_r.dac_output_word;
        default:  cur_nxt.err = 1'b1;
      endcase
    end

    if (access && pwrite && !cur_r.err) begin
      case (paddr)
        CTRL_OFF: cur_nxt.converter_control = pwdata[15:0];
        CHAN_OFF: cur_nxt.chan = pwdata[4:0];
        // keep only the sign and result fields, as in the data word
        DAC_OFF:  cur_nxt.dac_output_word = {pwdata[31:RES_LSB], 16'h0000};
        default:  cur_nxt.chan = cur_r.chan;
      endcase
    end

    // reading the result clears done; a finish in the same cycle wins
    if (rd_data) begin
      cur_nxt.done = 1'b0;
    end

    // divider only runs while a conversion is in flight
    if (cur_r.st == ST_IDLE || tick) begin
      cur_nxt.div_cnt = 8'h00;
    end else begin
      cur_nxt.div_cnt = cur_r.div_cnt + 8'h01;
    end

    case (cur_r.st)
      ST_IDLE: begin
        if (start) begin
          cur_nxt.st      = ST_ACQ;
          cur_nxt.clk_cnt = 8'h00;
          cur_nxt.temp    = cur_r.chan == TEMP_CHAN;
        end
      end
      ST_ACQ: begin
        if (tick) begin
          if (cur_r.clk_cnt == acq_n - 8'h01) begin
            cur_nxt.st      = ST_CONV;
            cur_nxt.clk_cnt = 8'h00;
          end else begin
            cur_nxt.clk_cnt = cur_r.clk_cnt + 8'h01;
          end
        end
      end
      ST_CONV: begin
        if (last_trial) begin
          cur_nxt.st      = ST_IDLE;
          cur_nxt.clk_cnt = 8'h00;
          cur_nxt.data    = fmt_word;
          cur_nxt.done    = 1'b1;
          cur_nxt.finish  = 1'b1;
          cur_nxt.temp    = 1'b0;
        end else if (tick) begin
          cur_nxt.clk_cnt = cur_r.clk_cnt + 8'h01;
        end
      end
      default: begin
        cur_nxt.st = ST_IDLE;
      end
    endcase

    // dropping enable abandons a conversion without touching the result
    if (!enabled && cur_r.st != ST_IDLE) begin
      cur_nxt.st      = ST_IDLE;
      cur_nxt.clk_cnt = 8'h00;
      cur_nxt.temp    = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_r <= RESET_STATE;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata       = cur_r.rdata;
  assign pready       = 1'b1;
  assign pslverr      = access & cur_r.err;
  assign converter_on = enabled;
  assign conv_tick    = tick;
  assign acquire      = cur_r.st == ST_ACQ;
  assign bit_trial    = cur_r.st == ST_CONV;
  assign conv_done    = cur_r.finish;
  assign chan_sel     = cur_r.chan;
  assign input_mode   = cur_r.converter_control[MODE_LSB +: 2];
  assign dac_code     = cur_r.dac_output_word[RES_MSB:RES_LSB];
  // limitation: only the reduced variant has the internal route
  assign buffered_dac_input_channel = REDUCED_VARIANT &&
                                      (cur_r.chan == BUF_DAC_CHAN);

  // ****************************************************************
  // checks
  // ****************************************************************
  logic        raw_msb;
  logic [11:0] wr_field;
  logic        dac_wr;
  assign raw_msb  = sar_result[11];
  assign wr_field = pwdata[RES_MSB:RES_LSB];
  assign dac_wr   = access & pwrite & ~cur_r.err & (paddr == DAC_OFF);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_result_place: assert property (
    last_trial && enabled |=> cur_r.data[15:0] == 16'h0000 && cur_r.done)
    else $error("result not placed in bits 16 to 27");

  a_sign_fill: assert property (
    last_trial && enabled |=>
      cur_r.data[31:SIGN_LSB] == ($past(diff_mode) ? {4{cur_r.data[RES_MSB]}} : 4'h0))
    else $error("upper bits are not sign copies");

  a_twos_comp: assert property (
    last_trial && enabled && diff_mode |=> cur_r.data[RES_MSB] != $past(raw_msb))
    else $error("differential result not two's complement");

  a_straight_bin: assert property (
    last_trial && enabled && !diff_mode |=>
      cur_r.data[RES_MSB:RES_LSB] == $past(sar_result))
    else $error("single-ended result not straight binary");

  a_dac_place: assert property (
    dac_wr |=> dac_code == $past(wr_field))
    else $error("dac word field misplaced");

  a_acq_end: assert property (
    cur_r.st == ST_ACQ && tick && cur_r.clk_cnt == acq_n - 8'h01 && enabled
      |=> cur_r.st == ST_CONV && cur_r.clk_cnt == 8'h00)
    else $error("acquisition did not end on its count");

  a_trial_count: assert property (
    cur_r.st == ST_CONV |-> cur_r.clk_cnt < EXTRA_CLKS)
    else $error("bit trial count overran");

  a_temp_timing: assert property (
    tick && cur_r.temp && enabled && !last_trial |=> !tick [*8])
    else $error("temperature divider not applied");

  a_temp_restore: assert property (
    cur_r.st == ST_IDLE |-> !cur_r.temp)
    else $error("temperature timing not released");

  a_start_acq: assert property (
    start |=> cur_r.st == ST_ACQ && cur_r.clk_cnt == 8'h00)
    else $error("start did not enter acquisition");

  a_result_hold: assert property (
    !last_trial |=> $stable(cur_r.data))
    else $error("result changed without a conversion");

  a_buf_route: assert property (
    buffered_dac_input_channel |-> REDUCED_VARIANT && chan_sel == BUF_DAC_CHAN)
    else $error("buffered channel routed wrongly");

  a_abort_keeps_data: assert property (
    !enabled && cur_r.st != ST_IDLE |=>
      cur_r.st == ST_IDLE && !conv_done && $stable(cur_r.data))
    else $error("aborted conversion touched the result");

  a_done_set_wins: assert property (
    last_trial |=> cur_r.done && conv_done)
    else $error("finished conversion did not flag done");

  a_data_readonly: assert property (
    setup && pwrite && paddr == DATA_OFF |=> cur_r.err)
    else $error("write to the result word not refused");

  a_temp_acq_len: assert property (
    $rose(bit_trial) && cur_r.temp |-> $past(cur_r.clk_cnt) == TEMP_ACQ_CLKS - 8'h01)
    else $error("temperature acquisition not sixteen clocks");

  a_dac_low_zero: assert property (
    dac_wr |=> cur_r.dac_output_word[15:0] == 16'h0000)
    else $error("dac word low bits not cleared");

  a_restart_cont: assert property (
    conv_done && enabled && conv_type == CONV_CONT && !access |=> acquire)
    else $error("continuous conversion did not restart");

endmodule // adc_result_ctrl

`default_nettype wire

//--- testbench/sar_core_model.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// converter core seen from the control block
// ****************************************************************
module sar_core_model (
  input  wire logic        bit_trial,
  input  wire logic        buffered_dac_input_channel,
  input  wire logic [11:0] dac_code,
  input  wire logic [11:0] level,
  output var  logic [11:0] sar_result
);
  logic [11:0] src;

  always_comb begin
    src = buffered_dac_input_channel ? dac_code : level;
    // outside the trials the code is not valid, so show a wrong one there
    sar_result = bit_trial ? src : ~src;
  end
endmodule // sar_core_model

`default_nettype wire

//--- testbench/adc_result_and_timing_control_tb.sv
`timescale 1ns/10ps
`default_nettype none

module adc_result_and_timing_control_tb;
  import adc_ctrl_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, last_data;
  logic [11:0] sar_result, dac_code, level, v;
  logic        converter_on, conv_tick, acquire, bit_trial, conv_done, bufch;
  logic [4:0]  chan_sel;
  logic [1:0]  input_mode;
  logic [1:0]  modes [3];
  logic [32:0] exp_q [$];
  logic [32:0] note;
  int          fails, checks, seed, k;

  adc_result_ctrl #(.REDUCED_VARIANT(1'b1)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sar_result(sar_result), .converter_on(converter_on), .conv_tick(conv_tick),
    .acquire(acquire), .bit_trial(bit_trial), .conv_done(conv_done), .chan_sel(chan_sel),
    .input_mode(input_mode), .dac_code(dac_code), .buffered_dac_input_channel(bufch));

  sar_core_model core (.bit_trial(bit_trial), .buffered_dac_input_channel(bufch),
    .dac_code(dac_code), .level(level), .sar_result(sar_result));

  always #4 pclk = ~pclk;

  // ****************************************************************
  // reporting
  // ****************************************************************
  task automatic end_sim;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  // answers are judged where they appear, against the oldest note
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      checks++;
      if (pslverr !== note[32] || (pwrite === 1'b0 && prdata !== note[31:0])) begin
        fails++;
        $display("[ERR] %0t bus answer wrong at %h", $time, paddr);
      end
    end
  end

  // ****************************************************************
  // bus master
  // ****************************************************************
  task automatic apb(input logic wr, input logic [31:0] a, d, input logic err);
    int n;
    exp_q.push_back({err, d});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      fails++;
      $display("[ERR] %0t no ready", $time);
      end_sim;
    end
  endtask

  // one-shot conversion, timed from the write to the done pulse
  task automatic conv(input logic [1:0] m, input logic [4:0] ch, input logic [1:0] acq,
                      input logic [2:0] dv);
    int n, e, t;
    logic [11:0] r;
    logic [31:0] d;
    level <= 12'($random(seed));
    apb(1'b1, CHAN_OFF, {27'h0, ch}, 1'b0);
    r = (ch == BUF_DAC_CHAN) ? dac_code : level;
    e = (ch == TEMP_CHAN) ? 32 * (16 + 19) : (1 << dv) * ((2 << acq) + 19);
    d = (m == MODE_DIFF) ? {{5{~r[11]}}, r[10:0], 16'h0} : {4'h0, r, 16'h0};
    apb(1'b1, CTRL_OFF, {16'h0, 3'h0, dv, acq, 2'h0, 1'b1, m, CONV_ONCE}, 1'b0);
    @(negedge pclk);
    check(converter_on === 1'b1 && input_mode === m, "control fields not applied");
    check(acquire === 1'b1 && chan_sel === ch, "acquisition not started");
    t = conv_tick;
    n = 0;
    while (conv_done !== 1'b1 && n < 2000) begin
      @(negedge pclk);
      n++;
      t += conv_tick;
    end
    if (n >= 2000) begin
      fails++;
      $display("[ERR] %0t conversion never ended", $time);
      end_sim;
    end
    check(n >= e && n <= e + 4, "conversion length off");
    check(t == ((ch == TEMP_CHAN) ? 35 : (2 << acq) + 19), "converter clocks off");
    apb(1'b0, STAT_OFF, 32'h1, 1'b0);
    apb(1'b0, DATA_OFF, d, 1'b0);
    apb(1'b0, DATA_OFF, d, 1'b0);
    last_data = d;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    level = 12'h0;
    fails = 0;
    checks = 0;
    seed = 56;
    modes = '{MODE_SINGLE, MODE_DIFF, MODE_PSEUDO};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_OFF, 32'h0000_0600, 1'b0);
    apb(1'b0, DATA_OFF, 32'h0, 1'b0);
    apb(1'b0, 32'hffff0508, 32'h0, 1'b1);
    apb(1'b1, DATA_OFF, 32'h1234_5678, 1'b1);
    apb(1'b0, DATA_OFF, 32'h0, 1'b0);
    for (k = 0; k < 3; k++) conv(modes[k], 5'h01, 2'h2, 3'h1);
    conv(MODE_SINGLE, TEMP_CHAN, 2'h2, 3'h1);
    conv(MODE_DIFF, 5'h02, 2'h0, 3'h0);
    v = 12'($random(seed));
    apb(1'b1, DAC_OFF, {4'h0, v, 16'h0}, 1'b0);
    @(negedge pclk);
    check(dac_code === v, "dac word field misplaced");
    conv(MODE_SINGLE, BUF_DAC_CHAN, 2'h1, 3'h2);
    check(bufch === 1'b1, "buffered channel not routed");
    // abort a slow conversion early in its acquisition: data must stay, no done
    apb(1'b1, CHAN_OFF, 32'h1, 1'b0);
    apb(1'b1, CTRL_OFF, {16'h0, 3'h7, 2'h2, 2'h0, 1'b1, MODE_SINGLE, CONV_ONCE}, 1'b0);
    repeat (100) @(negedge pclk);
    apb(1'b1, CTRL_OFF, {16'h0, 3'h7, 2'h2, 2'h0, 1'b0, MODE_SINGLE, CONV_ONCE}, 1'b0);
    k = 0;
    repeat (400) begin
      @(negedge pclk);
      if (conv_done === 1'b1) k++;
    end
    check(k == 0 && converter_on === 1'b0, "aborted conversion completed");
    apb(1'b0, DATA_OFF, last_data, 1'b0);
    repeat (4) conv(modes[$unsigned($random(seed)) % 3], 5'h05, 2'($random(seed)),
                    3'($unsigned($random(seed)) % 3));
    // continuous conversions restart on their own until enable drops
    apb(1'b1, CHAN_OFF, 32'h5, 1'b0);
    apb(1'b0, CHAN_OFF, 32'h5, 1'b0);
    apb(1'b1, CTRL_OFF, {16'h0, 10'h0, 1'b1, MODE_SINGLE, CONV_CONT}, 1'b0);
    k = 0;
    repeat (100) begin
      @(negedge pclk);
      if (conv_done === 1'b1) k++;
    end
    check(k == 4, "continuous mode did not restart");
    apb(1'b1, CTRL_OFF, 32'h0, 1'b0);
    apb(1'b0, DATA_OFF, {4'h0, level, 16'h0}, 1'b0);
    end_sim;
  end
endmodule // adc_result_and_timing_control_tb

`default_nettype wire
